// ===== design/sfrc_pkg.sv
// Shared constants and carrier types for the special-function register core
`default_nettype none
package sfrc_pkg;

    // ------------------------------------------------------------
    // Special-function register addresses (direct address space)
    // ------------------------------------------------------------
    localparam logic [7:0] SFRC_ADDR_IPORT_A = 8'h00;
    localparam logic [7:0] SFRC_ADDR_PTR_A = 8'h01;
    localparam logic [7:0] SFRC_ADDR_IPORT_B = 8'h02;
    localparam logic [7:0] SFRC_ADDR_PTR_B = 8'h03;
    localparam logic [7:0] SFRC_ADDR_BANK = 8'h04;
    localparam logic [7:0] SFRC_ADDR_PCL = 8'h06;
    localparam logic [7:0] SFRC_ADDR_TBLP = 8'h07;
    localparam logic [7:0] SFRC_ADDR_TABLE_HIGH_BYTE = 8'h08;
    localparam logic [7:0] SFRC_ADDR_FLAGS = 8'h0a;
    // First general-purpose location; below it lies the SFR area
    localparam logic [7:0] SFRC_GP_BASE = 8'h40;

    // ------------------------------------------------------------
    // Flag register fields and reset values
    // ------------------------------------------------------------
    localparam int SFRC_BIT_C = 0;
    localparam int SFRC_BIT_AC = 1;
    localparam int SFRC_BIT_Z = 2;
    localparam int SFRC_BIT_OV = 3;
    localparam int SFRC_BIT_PDF = 4;
    localparam int SFRC_BIT_TO = 5;
    localparam logic [3:0] SFRC_ARITH_RST = 4'h0;
    localparam logic [7:0] SFRC_BYTE_RST = 8'h00;
    localparam logic [7:0] SFRC_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Operation codes of the flag-producing datapath
    // ------------------------------------------------------------
    localparam logic [2:0] SFRC_OP_ADD = 3'h0;
    localparam logic [2:0] SFRC_OP_SUB = 3'h1;
    localparam logic [2:0] SFRC_OP_RLC = 3'h2;
    localparam logic [2:0] SFRC_OP_RRC = 3'h3;
    localparam logic [2:0] SFRC_OP_AND = 3'h4;
    localparam logic [2:0] SFRC_OP_OR = 3'h5;
    localparam logic [2:0] SFRC_OP_XOR = 3'h6;

    // ------------------------------------------------------------
    // Table read sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SFRC_TB_IDLE = 3'b001,
        SFRC_TB_FETCH = 3'b010,
        SFRC_TB_LOAD = 3'b100
    } sfrc_tb_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfrc_acc_s;

    typedef struct packed {
        logic valid;
        logic [2:0] op;
        logic [7:0] opa;
        logic [7:0] opb;
    } sfrc_alu_s;

    typedef struct packed {
        logic halt;
        logic wdt_clear;
        logic wdt_timeout;
        logic wdt_reset;
        logic sys_reset;
    } sfrc_evt_s;

endpackage
`default_nettype wire

// ===== design/sfrc_dmem.sv
// Data memory array with registered read data
`default_nettype none
module sfrc_dmem #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_n_i, // Asynchronous reset, active low
    input wire logic en_i, // Access enable
    input wire logic we_i, // Write when set, read otherwise
    input wire logic [AW-1:0] addr_i, // Word address
    input wire logic [DW-1:0] wdata_i, // Write data
    output logic [DW-1:0] rdata_o // Read data, one cycle after en_i
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (en_i && !we_i) begin
            rdata_next = mem[addr_i];
        end
    end

    // Array has no reset: contents are undefined after power-up anyway
    always_ff @(posedge sys_clk_i) begin
        if (en_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// ===== design/sfrc_core.sv
// Special-function register core: indirect ports, bank, PROG_COUNTER_LOW, table, flags
`default_nettype none
// Overview of operation
// - Indirect port accesses memory at its pointer
// - Port A reaches bank 0; port B any bank
// - Indirect access to indirect port: zero, no write
// - Bank bit 0 selects bank; upper bits zero
// - Resets clear bank except watchdog during power-down
// - SFR decode ignores bank selection
// - PROG_COUNTER_LOW write jumps within current page
// - PROG_COUNTER_LOW jump inserts one dummy cycle
// - Table read loads high byte, returns low
// - Flag writes change arithmetic flags only
// - Timeout flag: timeout sets, clear/halt/power-up clears
// - Power-down flag: halt sets, clear/power-up clears
// - Carry from add, no-borrow, rotate through carry
// - Half carry from low nibble carry/no-borrow
// - Zero flag set on zero result, except rotates, which leave it
// - Overflow is carry-in xor carry-out of MSB
// - Flags never saved automatically on call/interrupt
// - Upper flag bits zero; system flags zero at power-up
// - Unused special locations read zero
module sfrc_core
    import sfrc_pkg::*;
#(
    parameter int PC_W = 12,
    parameter int PM_W = 16
) (
    input wire logic sys_clk_i, // System clock, 10 MHz
    input wire logic rst_n_i, // Power-on reset, async, active low
    input wire sfrc_pkg::sfrc_acc_s acc_i, // Data access from execution
    input wire sfrc_pkg::sfrc_alu_s alu_i, // Flag-producing operation
    input wire sfrc_pkg::sfrc_evt_s evt_i, // System event pulses
    input wire logic tbl_req_i, // Table read request pulse
    input wire logic [PC_W-1:0] pc_i, // Current program counter
    input wire logic [PM_W-1:0] pm_data_i, // Program word, cycle after rd
    output logic [7:0] rd_data_o, // Read data
    output logic rd_valid_o, // Read data valid pulse
    output logic [7:0] alu_result_o, // Operation result
    output logic alu_valid_o, // Result valid pulse
    output logic jump_o, // Jump request pulse
    output logic [PC_W-1:0] jump_addr_o, // Jump target
    output logic dummy_cycle_o, // Dummy cycle pulse after jump
    output logic pm_rd_o, // Program memory read strobe
    output logic [PC_W-1:0] pm_addr_o, // Program memory address
    output logic [7:0] tbl_low_o, // Table low byte
    output logic tbl_done_o, // Table read complete pulse
    output logic [7:0] flags_o, // Flag register image
    output logic bank_o // Current data bank
);
    import sfrc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ptr_a_reg, ptr_a_next;
    logic [7:0] ptr_b_reg, ptr_b_next;
    logic bank_reg, bank_next;
    logic [7:0] tblp_reg, tblp_next;
    logic [7:0] table_high_byte_reg, table_high_byte_next;
    logic [3:0] arith_reg, arith_next;
    logic to_reg, to_next;
    logic pdf_reg, pdf_next;
    logic rd_ram_reg, rd_ram_next;
    logic rd_pend_reg, rd_pend_next;
    logic [7:0] sfr_cap_reg, sfr_cap_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic [7:0] alu_res_reg, alu_res_next;
    logic alu_valid_reg, alu_valid_next;
    logic jump_reg, jump_next;
    logic [PC_W-1:0] jump_addr_reg, jump_addr_next;
    logic dummy_reg, dummy_next;
    sfrc_tb_e tb_state_reg, tb_state_next;
    logic [PC_W-1:0] pm_addr_reg, pm_addr_next;
    logic [7:0] tbl_low_reg, tbl_low_next;
    logic tbl_done_reg, tbl_done_next;

    // ------------------------------------------------------------
    // Address resolution
    // ------------------------------------------------------------
    logic indirect;
    logic [8:0] eff_addr;
    logic null_acc;
    logic is_sfr;
    logic ram_en;
    logic [7:0] ram_rdata;
    logic [7:0] sfr_rd;
    logic [7:0] flag_img;

    always_comb begin
        indirect = 1'b0;
        eff_addr = {1'b0, acc_i.addr};
        if (acc_i.addr == SFRC_ADDR_IPORT_A) begin
            indirect = 1'b1;
            eff_addr = {1'b0, ptr_a_reg};
        end else if (acc_i.addr == SFRC_ADDR_IPORT_B) begin
            indirect = 1'b1;
            eff_addr = {bank_reg, ptr_b_reg};
        end
    end

    // Pointer aimed back at a port: nothing is read or written
    assign null_acc = indirect && (eff_addr[7:0] == SFRC_ADDR_IPORT_A ||
        eff_addr[7:0] == SFRC_ADDR_IPORT_B);
    assign is_sfr = eff_addr[7:0] < SFRC_GP_BASE;
    assign ram_en = acc_i.valid && !null_acc && !is_sfr;
    assign flag_img = {2'b00, to_reg, pdf_reg, arith_reg};

    sfrc_dmem #(
        .AW(9),
        .DW(8)
    ) u_dmem (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(ram_en),
        .we_i(acc_i.write),
        .addr_i(eff_addr),
        .wdata_i(acc_i.wdata),
        .rdata_o(ram_rdata)
    );

    // ------------------------------------------------------------
    // SFR read decode
    // ------------------------------------------------------------
    always_comb begin
        sfr_rd = SFRC_ZERO;
        if (null_acc) begin
            sfr_rd = SFRC_ZERO;
        end else if (eff_addr[7:0] == SFRC_ADDR_PTR_A) begin
            sfr_rd = ptr_a_reg;
        end else if (eff_addr[7:0] == SFRC_ADDR_PTR_B) begin
            sfr_rd = ptr_b_reg;
        end else if (eff_addr[7:0] == SFRC_ADDR_BANK) begin
            sfr_rd = {7'h00, bank_reg};
        end else if (eff_addr[7:0] == SFRC_ADDR_PCL) begin
            sfr_rd = pc_i[7:0];
        end else if (eff_addr[7:0] == SFRC_ADDR_TBLP) begin
            sfr_rd = tblp_reg;
        end else if (eff_addr[7:0] == SFRC_ADDR_TABLE_HIGH_BYTE) begin
            sfr_rd = table_high_byte_reg;
        end else if (eff_addr[7:0] == SFRC_ADDR_FLAGS) begin
            sfr_rd = flag_img;
        end
    end

    // ------------------------------------------------------------
    // Flag datapath
    // ------------------------------------------------------------
    logic [7:0] opb_eff;
    logic cin;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [7:0] sum_low7;
    logic [7:0] alu_res;
    logic alu_arith;

    always_comb begin
        opb_eff = (alu_i.op == SFRC_OP_SUB) ? ~alu_i.opb : alu_i.opb;
        cin = (alu_i.op == SFRC_OP_SUB);
        // Subtraction as a + ~b + 1, so carry out means no borrow
        sum9 = {1'b0, alu_i.opa} + {1'b0, opb_eff} + {8'h00, cin};
        sum_lo = {1'b0, alu_i.opa[3:0]} + {1'b0, opb_eff[3:0]} +
            {4'h0, cin};
        sum_low7 = {1'b0, alu_i.opa[6:0]} + {1'b0, opb_eff[6:0]} +
            {7'h00, cin};
        alu_arith = (alu_i.op == SFRC_OP_ADD) || (alu_i.op == SFRC_OP_SUB);
        alu_res = sum9[7:0];
        if (alu_i.op == SFRC_OP_RLC) begin
            alu_res = {alu_i.opa[6:0], arith_reg[SFRC_BIT_C]};
        end else if (alu_i.op == SFRC_OP_RRC) begin
            alu_res = {arith_reg[SFRC_BIT_C], alu_i.opa[7:1]};
        end else if (alu_i.op == SFRC_OP_AND) begin
            alu_res = alu_i.opa & alu_i.opb;
        end else if (alu_i.op == SFRC_OP_OR) begin
            alu_res = alu_i.opa | alu_i.opb;
        end else if (alu_i.op == SFRC_OP_XOR) begin
            alu_res = alu_i.opa ^ alu_i.opb;
        end
    end

    // ------------------------------------------------------------
    // Register and flag next state
    // ------------------------------------------------------------
    logic wr_hit;

    always_comb begin
        ptr_a_next = ptr_a_reg;
        ptr_b_next = ptr_b_reg;
        bank_next = bank_reg;
        tblp_next = tblp_reg;
        arith_next = arith_reg;
        to_next = to_reg;
        pdf_next = pdf_reg;
        jump_next = 1'b0;
        jump_addr_next = jump_addr_reg;
        dummy_next = jump_reg;
        alu_res_next = alu_res_reg;
        alu_valid_next = 1'b0;
        wr_hit = acc_i.valid && acc_i.write && !null_acc && is_sfr;
        if (wr_hit) begin
            if (eff_addr[7:0] == SFRC_ADDR_PTR_A) begin
                ptr_a_next = acc_i.wdata;
            end else if (eff_addr[7:0] == SFRC_ADDR_PTR_B) begin
                ptr_b_next = acc_i.wdata;
            end else if (eff_addr[7:0] == SFRC_ADDR_BANK) begin
                bank_next = acc_i.wdata[0];
            end else if (eff_addr[7:0] == SFRC_ADDR_PCL) begin
                jump_next = 1'b1;
                jump_addr_next = {pc_i[PC_W-1:8], acc_i.wdata};
            end else if (eff_addr[7:0] == SFRC_ADDR_TBLP) begin
                tblp_next = acc_i.wdata;
            end else if (eff_addr[7:0] == SFRC_ADDR_FLAGS) begin
                arith_next = acc_i.wdata[3:0];
            end
        end
        // An operation in the same cycle as a flag write overrides the flags that it updates
        if (alu_i.valid) begin
            alu_valid_next = 1'b1;
            alu_res_next = alu_res;
            if (alu_arith) begin
                arith_next[SFRC_BIT_C] = sum9[8];
                arith_next[SFRC_BIT_AC] = sum_lo[4];
                arith_next[SFRC_BIT_OV] = sum_low7[7] ^ sum9[8];
            end else if (alu_i.op == SFRC_OP_RLC) begin
                arith_next[SFRC_BIT_C] = alu_i.opa[7];
            end else if (alu_i.op == SFRC_OP_RRC) begin
                arith_next[SFRC_BIT_C] = alu_i.opa[0];
            end
            if (alu_i.op != SFRC_OP_RLC && alu_i.op != SFRC_OP_RRC) begin
                arith_next[SFRC_BIT_Z] = (alu_res == SFRC_ZERO);
            end
        end
        // Clears first, so a timeout or halt in the same cycle still sets
        if (evt_i.wdt_clear) begin
            to_next = 1'b0;
            pdf_next = 1'b0;
        end
        if (evt_i.halt) begin
            to_next = 1'b0;
            pdf_next = 1'b1;
        end
        if (evt_i.wdt_timeout) begin
            to_next = 1'b1;
        end
        if (evt_i.sys_reset || (evt_i.wdt_reset && !pdf_reg)) begin
            bank_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read return path: capture, then present
    // ------------------------------------------------------------
    always_comb begin
        rd_pend_next = acc_i.valid && !acc_i.write;
        rd_ram_next = ram_en && !acc_i.write;
        sfr_cap_next = sfr_rd;
        rd_valid_next = rd_pend_reg;
        rd_data_next = rd_data_reg;
        if (rd_pend_reg) begin
            rd_data_next = rd_ram_reg ? ram_rdata : sfr_cap_reg;
        end
    end

    // ------------------------------------------------------------
    // Table read sequencer
    // ------------------------------------------------------------
    always_comb begin
        tb_state_next = tb_state_reg;
        pm_addr_next = pm_addr_reg;
        table_high_byte_next = table_high_byte_reg;
        tbl_low_next = tbl_low_reg;
        tbl_done_next = 1'b0;
        case (tb_state_reg)
            SFRC_TB_IDLE: begin
                if (tbl_req_i) begin
                    // Pointer is taken within the current program page
                    pm_addr_next = {pc_i[PC_W-1:8], tblp_reg};
                    tb_state_next = SFRC_TB_FETCH;
                end
            end
            SFRC_TB_FETCH: begin
                tb_state_next = SFRC_TB_LOAD;
            end
            SFRC_TB_LOAD: begin
                table_high_byte_next = pm_data_i[15:8];
                tbl_low_next = pm_data_i[7:0];
                tbl_done_next = 1'b1;
                tb_state_next = SFRC_TB_IDLE;
            end
            default: begin
                tb_state_next = SFRC_TB_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // No save of the flags here: calls and interrupts leave them alone
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_a_reg <= SFRC_BYTE_RST;
            ptr_b_reg <= SFRC_BYTE_RST;
            bank_reg <= 1'b0;
            tblp_reg <= SFRC_BYTE_RST;
            table_high_byte_reg <= SFRC_BYTE_RST;
            arith_reg <= SFRC_ARITH_RST;
            to_reg <= 1'b0;
            pdf_reg <= 1'b0;
            rd_ram_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            sfr_cap_reg <= SFRC_BYTE_RST;
            rd_data_reg <= SFRC_BYTE_RST;
            rd_valid_reg <= 1'b0;
            alu_res_reg <= SFRC_BYTE_RST;
            alu_valid_reg <= 1'b0;
            jump_reg <= 1'b0;
            jump_addr_reg <= '0;
            dummy_reg <= 1'b0;
            tb_state_reg <= SFRC_TB_IDLE;
            pm_addr_reg <= '0;
            tbl_low_reg <= SFRC_BYTE_RST;
            tbl_done_reg <= 1'b0;
        end else begin
            ptr_a_reg <= ptr_a_next;
            ptr_b_reg <= ptr_b_next;
            bank_reg <= bank_next;
            tblp_reg <= tblp_next;
            table_high_byte_reg <= table_high_byte_next;
            arith_reg <= arith_next;
            to_reg <= to_next;
            pdf_reg <= pdf_next;
            rd_ram_reg <= rd_ram_next;
            rd_pend_reg <= rd_pend_next;
            sfr_cap_reg <= sfr_cap_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            alu_res_reg <= alu_res_next;
            alu_valid_reg <= alu_valid_next;
            jump_reg <= jump_next;
            jump_addr_reg <= jump_addr_next;
            dummy_reg <= dummy_next;
            tb_state_reg <= tb_state_next;
            pm_addr_reg <= pm_addr_next;
            tbl_low_reg <= tbl_low_next;
            tbl_done_reg <= tbl_done_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign alu_result_o = alu_res_reg;
    assign alu_valid_o = alu_valid_reg;
    assign jump_o = jump_reg;
    assign jump_addr_o = jump_addr_reg;
    assign dummy_cycle_o = dummy_reg;
    assign pm_rd_o = tb_state_reg[1];
    assign pm_addr_o = pm_addr_reg;
    assign tbl_low_o = tbl_low_reg;
    assign tbl_done_o = tbl_done_reg;
    assign flags_o = {2'b00, to_reg, pdf_reg, arith_reg};
    assign bank_o = bank_reg;
endmodule
`default_nettype wire

// ===== tb/sfrc_core_asserts.sv
// Port-level checks of the special-function register core
`default_nettype none
module sfrc_core_asserts
    import sfrc_pkg::*;
#(
    parameter int PC_W = 12
) (
    input wire logic sys_clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire sfrc_pkg::sfrc_acc_s acc_i, // Access
    input wire sfrc_pkg::sfrc_alu_s alu_i, // Operation
    input wire sfrc_pkg::sfrc_evt_s evt_i, // Events
    input wire logic [PC_W-1:0] pc_i, // Program counter
    input wire logic rd_valid_o, // Read valid
    input wire logic [7:0] alu_result_o, // Result
    input wire logic alu_valid_o, // Result valid
    input wire logic jump_o, // Jump
    input wire logic [PC_W-1:0] jump_addr_o, // Target
    input wire logic dummy_cycle_o, // Dummy cycle
    input wire logic pm_rd_o, // Program read
    input wire logic tbl_done_o, // Table done
    input wire logic [7:0] flags_o, // Flags
    input wire logic bank_o // Bank
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_pcl_jump: assert property (
        acc_i.valid && acc_i.write && acc_i.addr == SFRC_ADDR_PCL |=> jump_o
        && jump_addr_o[7:0] == $past(acc_i.wdata)
        && jump_addr_o[PC_W-1:8] == $past(pc_i[PC_W-1:8]))
        else $error("pcl write gave no jump to the right place");
    chk_dummy_after: assert property (jump_o |=> dummy_cycle_o)
        else $error("no dummy cycle after jump");
    chk_read_answer: assert property (
        acc_i.valid && !acc_i.write |-> ##2 rd_valid_o)
        else $error("read not answered two cycles later");
    chk_upper_zero: assert property (flags_o[7:6] == 2'b00)
        else $error("upper flag bits not zero");
    chk_halt_flags: assert property (
        evt_i.halt && !evt_i.wdt_timeout |=> flags_o[5:4] == 2'b01)
        else $error("halt did not set power-down and clear timeout");
    chk_clear_flags: assert property (
        evt_i.wdt_clear && !evt_i.halt && !evt_i.wdt_timeout
        |=> flags_o[5:4] == 2'b00)
        else $error("watchdog clear left system flags set");
    chk_timeout_set: assert property (evt_i.wdt_timeout |=> flags_o[5])
        else $error("timeout flag not set");
    chk_sys_hold: assert property (
        !(evt_i.halt || evt_i.wdt_clear || evt_i.wdt_timeout)
        |=> $stable(flags_o[5:4]))
        else $error("system flags moved without an event");
    chk_bank_reset: assert property (evt_i.sys_reset |=> !bank_o)
        else $error("reset left bank 1 selected");
    chk_zero_and: assert property (
        alu_i.valid && alu_i.op == SFRC_OP_AND |=> alu_valid_o
        && alu_result_o == ($past(alu_i.opa) & $past(alu_i.opb))
        && flags_o[SFRC_BIT_Z] == (alu_result_o == 8'h00))
        else $error("logic result or zero flag wrong");
    chk_table_seq: assert property (
        pm_rd_o |=> !pm_rd_o ##1 tbl_done_o)
        else $error("table read did not complete in sequence");
endmodule
bind sfrc_core sfrc_core_asserts #(.PC_W(PC_W)) chk_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .acc_i(acc_i),
    .alu_i(alu_i), .evt_i(evt_i), .pc_i(pc_i), .rd_valid_o(rd_valid_o),
    .alu_result_o(alu_result_o), .alu_valid_o(alu_valid_o),
    .jump_o(jump_o), .jump_addr_o(jump_addr_o),
    .dummy_cycle_o(dummy_cycle_o), .pm_rd_o(pm_rd_o),
    .tbl_done_o(tbl_done_o), .flags_o(flags_o), .bank_o(bank_o));
`default_nettype wire

// ===== tb/sfrc_pmem_model.sv
// Program memory model answering table reads
`default_nettype none
module sfrc_pmem_model #(
    parameter int PC_W = 12
) (
    input wire logic sys_clk_i, // Clock
    input wire logic pm_rd_i, // Read strobe
    input wire logic [PC_W-1:0] pm_addr_i, // Word address
    output logic [15:0] pm_data_o // Program word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic held_reg = 1'b0;
    logic [PC_W-1:0] addr_reg = '0;
    logic [15:0] junk_reg = 16'h5555;
    logic [7:0] lo;
    always_ff @(posedge sys_clk_i) begin
        held_reg <= pm_rd_i;
        if (pm_rd_i) begin
            addr_reg <= pm_addr_i;
        end
        junk_reg <= ~pm_data_o;
    end
    // Word stands during the strobe and one cycle after, junk otherwise
    assign lo = pm_rd_i ? pm_addr_i[7:0] : addr_reg[7:0];
    assign pm_data_o = (pm_rd_i || held_reg) ? {lo ^ 8'h5a, ~lo} : junk_reg;
endmodule
`default_nettype wire

// ===== tb/sfrc_core_bench.sv
// Self-checking bench of the special-function register core
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sfrc_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sfrc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    sfrc_acc_s acc = '0;
    sfrc_alu_s alu = '0;
    sfrc_evt_s evt = '0;
    logic tbl_req = 1'b0;
    logic [11:0] pc = 12'h345;
    logic [15:0] pm_data;
    logic [7:0] rd_data, alu_res, tbl_low, flags;
    logic rd_valid, alu_valid, jump, dummy, pm_rd, tbl_done, bank;
    logic [11:0] jump_addr, pm_addr;
    int mismatches = 0;
    int checked = 0;
    sfrc_core dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .acc_i(acc),
        .alu_i(alu), .evt_i(evt), .tbl_req_i(tbl_req), .pc_i(pc),
        .pm_data_i(pm_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .alu_result_o(alu_res), .alu_valid_o(alu_valid), .jump_o(jump),
        .jump_addr_o(jump_addr), .dummy_cycle_o(dummy), .pm_rd_o(pm_rd),
        .pm_addr_o(pm_addr), .tbl_low_o(tbl_low), .tbl_done_o(tbl_done),
        .flags_o(flags), .bank_o(bank));
    sfrc_pmem_model pm_u (.sys_clk_i(sys_clk_i), .pm_rd_i(pm_rd),
        .pm_addr_i(pm_addr), .pm_data_o(pm_data));
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic stop_test();
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i) acc <= {1'b1, 1'b1, a, d};
        @(posedge sys_clk_i) acc <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i) acc <= {1'b1, 1'b0, a, 8'h00};
        @(posedge sys_clk_i) acc <= '0;
        @(posedge sys_clk_i) #1;
        `CHK({rd_valid, rd_data}, {1'b1, e})
    endtask
    task automatic ev(input logic [4:0] e);
        @(posedge sys_clk_i) evt <= e;
        @(posedge sys_clk_i) evt <= '0;
        #1;
    endtask
    task automatic op(input logic [2:0] o, input logic [7:0] a, b, r,
        input logic [3:0] f);
        @(posedge sys_clk_i) alu <= {1'b1, o, a, b};
        @(posedge sys_clk_i) alu <= '0;
        #1;
        `CHK({alu_valid, alu_res, flags[3:0]}, {1'b1, r, f})
    endtask
    task automatic t_bank();
        wr(SFRC_ADDR_BANK, 8'hff);
        rd(SFRC_ADDR_BANK, 8'h01);
        ev(5'h01);
        `CHK(bank, 1'b0)
        wr(SFRC_ADDR_BANK, 8'h01);
        ev(5'h10);
        ev(5'h02);
        `CHK(bank, 1'b1)
        ev(5'h08);
        ev(5'h02);
        `CHK(bank, 1'b0)
    endtask
    task automatic t_ind();
        wr(SFRC_ADDR_PTR_A, 8'h50);
        wr(SFRC_ADDR_IPORT_A, 8'ha5);
        rd(8'h50, 8'ha5);
        wr(SFRC_ADDR_BANK, 8'h01);
        wr(SFRC_ADDR_PTR_B, 8'h50);
        wr(SFRC_ADDR_IPORT_B, 8'h3c);
        rd(SFRC_ADDR_IPORT_A, 8'ha5);
        rd(SFRC_ADDR_IPORT_B, 8'h3c);
        rd(SFRC_ADDR_PTR_B, 8'h50);
        wr(SFRC_ADDR_BANK, 8'h00);
        rd(SFRC_ADDR_IPORT_B, 8'ha5);
        wr(SFRC_ADDR_PTR_A, SFRC_ADDR_IPORT_B);
        wr(SFRC_ADDR_IPORT_A, 8'h77);
        rd(SFRC_ADDR_IPORT_A, 8'h00);
        rd(8'h50, 8'ha5);
        rd(8'h05, 8'h00);
    endtask
    task automatic t_pcl_tbl();
        wr(SFRC_ADDR_PCL, 8'h12);
        #1;
        `CHK({jump, jump_addr}, {1'b1, 12'h312})
        @(posedge sys_clk_i) #1;
        `CHK({jump, dummy}, 2'b01)
        rd(SFRC_ADDR_PCL, 8'h45);
        wr(SFRC_ADDR_TBLP, 8'h06);
        @(posedge sys_clk_i) tbl_req <= 1'b1;
        @(posedge sys_clk_i) tbl_req <= 1'b0;
        #1;
        `CHK({pm_rd, pm_addr}, {1'b1, 12'h306})
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK({tbl_done, tbl_low}, {1'b1, 8'hf9})
        rd(SFRC_ADDR_TABLE_HIGH_BYTE, 8'h5c);
    endtask
    task automatic t_flags();
        wr(SFRC_ADDR_FLAGS, 8'hff);
        rd(SFRC_ADDR_FLAGS, 8'h0f);
        op(SFRC_OP_ADD, 8'h7f, 8'h01, 8'h80, 4'ha);
        op(SFRC_OP_SUB, 8'h10, 8'h10, 8'h00, 4'h7);
        op(SFRC_OP_RLC, 8'h00, 8'h00, 8'h01, 4'h6);
        op(SFRC_OP_RRC, 8'h01, 8'h00, 8'h00, 4'h7);
        op(SFRC_OP_OR, 8'h00, 8'h01, 8'h01, 4'h3);
        op(SFRC_OP_AND, 8'hf0, 8'h0f, 8'h00, 4'h7);
        op(SFRC_OP_XOR, 8'h55, 8'haa, 8'hff, 4'h3);
        op(SFRC_OP_ADD, 8'h80, 8'h80, 8'h00, 4'hd);
        ev(5'h10);
        `CHK(flags[5:4], 2'b01)
        ev(5'h04);
        `CHK(flags[5:4], 2'b11)
        wr(SFRC_ADDR_FLAGS, 8'h00);
        rd(SFRC_ADDR_FLAGS, 8'h30);
        ev(5'h08);
        `CHK(flags, 8'h00)
        ev(5'h04);
        ev(5'h10);
        `CHK(flags[5:4], 2'b01)
    endtask
    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        `CHK(flags[7:4], 4'h0)
        t_bank();
        t_ind();
        t_pcl_tbl();
        t_flags();
        stop_test();
    end
    // Whole run needs about 110 cycles; give it ample margin
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        mismatches++;
        stop_test();
    end
endmodule
`undef CHK
`default_nettype wire
